// ==== hw/icep_pkg.sv ====
// Package for the interrupt clear-enable / set-pending register block
package icep_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [31:0] ADDR_ENABLE_SET_LOWER  = 32'he000e100;
  localparam logic [31:0] ADDR_ENABLE_SET_UPPER  = 32'he000e104;
  localparam logic [31:0] ADDR_DISABLE_LOWER     = 32'he000e180;
  localparam logic [31:0] ADDR_DISABLE_UPPER     = 32'he000e184;
  localparam logic [31:0] ADDR_PEND_SET_LOWER    = 32'he000e200;
  localparam logic [31:0] ADDR_PEND_SET_UPPER    = 32'he000e204;
  localparam logic [31:0] ADDR_PEND_CLEAR_LOWER  = 32'he000e280;
  localparam logic [31:0] ADDR_PEND_CLEAR_UPPER  = 32'he000e284;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          NUM_IRQ                = 64;
  localparam int          GROUP_W                = 32;
  localparam logic [31:0] UPPER_IMPL_MASK        = 32'h03efffff;
  localparam logic [31:0] READ_UNMAPPED          = 32'h00000000;
  localparam logic [63:0] ENABLE_RESET           = 64'h0000000000000000;
  localparam logic [63:0] PEND_RESET             = 64'h0000000000000000;
  localparam logic [63:0] IMPL_MASK              = {UPPER_IMPL_MASK, 32'hffffffff};

  // Upper group bit positions
  localparam int          BIT_WAKE_P2_8          = 0;
  localparam int          BIT_WAKE_P3_3          = 7;
  localparam int          BIT_TWO_WIRE           = 8;
  localparam int          BIT_TIMER32_B          = 12;
  localparam int          BIT_SYNC_SERIAL_A      = 13;
  localparam int          BIT_BROWNOUT           = 19;
  localparam int          BIT_PORT3              = 21;
  localparam int          BIT_PORT0              = 24;
  localparam int          BIT_SYNC_SERIAL_B      = 25;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ICEP_R_NONE       = 3'b000,
    ICEP_R_ENA_SET    = 3'b001,
    ICEP_R_DISABLE    = 3'b010,
    ICEP_R_PEND_SET   = 3'b011,
    ICEP_R_PEND_CLEAR = 3'b100
  } icep_reg_e;

  typedef struct packed {
    icep_reg_e kind;
    logic      upper;
  } icep_sel_s;

  typedef struct packed {
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } icep_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic        readdatavalid;
  } icep_rsp_s;

  typedef enum logic [0:0] {
    ICEP_IDLE = 1'b0,
    ICEP_DONE = 1'b1
  } icep_state_e;

endpackage : icep_pkg

// ==== hw/icep_regs.sv ====
// Interrupt enable and pending state with its Avalon-MM register slave
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module icep_regs (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire logic [31:0]               avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [3:0]                avs_byteenable,
  input  wire logic [31:0]               avs_writedata,
  output      logic [31:0]               avs_readdata,
  output      logic                      avs_waitrequest,
  input  wire logic [icep_pkg::NUM_IRQ-1:0] irq_src,
  output      logic [icep_pkg::NUM_IRQ-1:0] irq_enabled,
  output      logic [icep_pkg::NUM_IRQ-1:0] irq_pending,
  output      logic [icep_pkg::NUM_IRQ-1:0] irq_active
);
  import icep_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic icep_sel_s decode(input logic [31:0] addr);
    icep_sel_s s;
    s.kind  = ICEP_R_NONE;
    s.upper = 1'b0;
    unique case (addr)
      ADDR_ENABLE_SET_LOWER: begin
        s.kind = ICEP_R_ENA_SET;
      end
      ADDR_ENABLE_SET_UPPER: begin
        s.kind  = ICEP_R_ENA_SET;
        s.upper = 1'b1;
      end
      ADDR_DISABLE_LOWER: begin
        s.kind = ICEP_R_DISABLE;
      end
      ADDR_DISABLE_UPPER: begin
        s.kind  = ICEP_R_DISABLE;
        s.upper = 1'b1;
      end
      ADDR_PEND_SET_LOWER: begin
        s.kind = ICEP_R_PEND_SET;
      end
      ADDR_PEND_SET_UPPER: begin
        s.kind  = ICEP_R_PEND_SET;
        s.upper = 1'b1;
      end
      ADDR_PEND_CLEAR_LOWER: begin
        s.kind = ICEP_R_PEND_CLEAR;
      end
      ADDR_PEND_CLEAR_UPPER: begin
        s.kind  = ICEP_R_PEND_CLEAR;
        s.upper = 1'b1;
      end
      default: begin
        s.kind = ICEP_R_NONE;
      end
    endcase
    return s;
  endfunction : decode

  function automatic logic [63:0] place(input logic upper, input logic [31:0] v);
    return upper ? {v, 32'h00000000} : {32'h00000000, v};
  endfunction : place

  // ****************************************
  // Source synchronisers
  // ****************************************
  // Sources are pins; an edge counts once stages two and three agree
  logic [NUM_IRQ-1:0] src_s1;
  logic [NUM_IRQ-1:0] src_s2;
  logic [NUM_IRQ-1:0] src_s3;
  logic [NUM_IRQ-1:0] src_lvl;
  logic [NUM_IRQ-1:0] next_src_lvl;
  logic [NUM_IRQ-1:0] src_rise;

  always_comb begin
    next_src_lvl = src_lvl;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (src_s2[i] == src_s3[i]) begin
        next_src_lvl[i] = src_s3[i];
      end
    end
  end

  assign src_rise = next_src_lvl & ~src_lvl;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_s1  <= '0;
      src_s2  <= '0;
      src_s3  <= '0;
      src_lvl <= '0;
    end else if (clk_en) begin
      src_s1  <= irq_src;
      src_s2  <= src_s1;
      src_s3  <= src_s2;
      src_lvl <= next_src_lvl;
    end
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait state gives a registered read path
  icep_state_e state;
  icep_state_e next_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  icep_sel_s   sel;
  logic        access;
  logic        commit;
  logic [31:0] wmask;
  logic [63:0] wbits;

  assign sel    = decode(avs_address);
  assign access = avs_read | avs_write;
  assign commit = access && (state == ICEP_DONE);
  // Hold the master off while frozen, else a write could be lost
  assign avs_waitrequest = access && ((state == ICEP_IDLE) || !clk_en);
  assign avs_readdata    = rdata;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // Reserved upper bits are masked off even if written
  assign wbits = place(sel.upper, avs_writedata & wmask) & IMPL_MASK;

  // ****************************************
  // Enable and pending state
  // ****************************************
  logic [NUM_IRQ-1:0] enable_q;
  logic [NUM_IRQ-1:0] pend_q;
  logic [NUM_IRQ-1:0] next_enable;
  logic [NUM_IRQ-1:0] next_pend;
  logic               wr_go;

  assign wr_go = commit && avs_write;

  always_comb begin
    next_enable = enable_q;
    next_pend   = pend_q;
    if (wr_go) begin
      unique case (sel.kind)
        ICEP_R_ENA_SET: begin
          next_enable = enable_q | wbits;
        end
        ICEP_R_DISABLE: begin
          next_enable = enable_q & ~wbits;
        end
        ICEP_R_PEND_SET: begin
          next_pend = pend_q | wbits;
        end
        ICEP_R_PEND_CLEAR: begin
          next_pend = pend_q & ~wbits;
        end
        default: begin
          next_pend = pend_q;
        end
      endcase
    end
    // Hardware request wins over a same-cycle clear
    next_pend = (next_pend | src_rise) & IMPL_MASK;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= ENABLE_RESET;
      pend_q   <= PEND_RESET;
    end else if (clk_en) begin
      enable_q <= next_enable;
      pend_q   <= next_pend;
    end
  end

  // ****************************************
  // Read data and handshake state
  // ****************************************
  always_comb begin
    next_state = ICEP_IDLE;
    next_rdata = rdata;
    unique case (state)
      ICEP_IDLE: begin
        if (access) begin
          next_state = ICEP_DONE;
          next_rdata = READ_UNMAPPED;
          unique case (sel.kind)
            ICEP_R_ENA_SET, ICEP_R_DISABLE: begin
              next_rdata = sel.upper ? (enable_q[63:32] & UPPER_IMPL_MASK) : enable_q[31:0];
            end
            ICEP_R_PEND_SET, ICEP_R_PEND_CLEAR: begin
              next_rdata = sel.upper ? (pend_q[63:32] & UPPER_IMPL_MASK) : pend_q[31:0];
            end
            default: begin
              next_rdata = READ_UNMAPPED;
            end
          endcase
        end
      end
      ICEP_DONE: begin
        next_state = ICEP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ICEP_IDLE;
      rdata <= '0;
    end else if (clk_en) begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  assign irq_enabled = enable_q;
  assign irq_pending = pend_q;
  assign irq_active  = enable_q & pend_q;

endmodule : icep_regs

// ==== testbench/icep_regs_monitor.sv ====
// Checker on the interrupt register block ports
`timescale 1ns/1ps
module icep_regs_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [63:0] irq_src,
  input wire logic [63:0] irq_enabled,
  input wire logic [63:0] irq_pending,
  input wire logic [63:0] irq_active
);
  import icep_pkg::*;
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic wr_acc = avs_write && !avs_waitrequest && clk_en;
  wire logic wr_ok  = wr_acc && avs_byteenable == 4'hf;
  wire logic rd_ok  = avs_read && !avs_waitrequest && clk_en;
  property p_dis;
    wr_ok && avs_address == ADDR_DISABLE_UPPER |=> irq_enabled == ($past(irq_enabled) & ~{$past(avs_writedata), 32'h0});
  endproperty
  a_dis: assert property (p_dis) else $error("disable write");
  // Lower and upper set-enable share address bits 31:3
  property p_en;
    (irq_enabled & ~$past(irq_enabled)) != 64'h0 |-> $past(wr_acc) && $past(avs_address[31:3]) == ADDR_ENABLE_SET_LOWER[31:3];
  endproperty
  a_en: assert property (p_en) else $error("enable rose");
  property p_pset;
    wr_ok && avs_address == ADDR_PEND_SET_LOWER |=> (($past(irq_pending[31:0]) | $past(avs_writedata)) & ~irq_pending[31:0]) == 0;
  endproperty
  a_pset: assert property (p_pset) else $error("pend set");
  property p_pup;
    wr_ok && avs_address == ADDR_PEND_SET_UPPER |=> ($past(avs_writedata) & UPPER_IMPL_MASK & ~irq_pending[63:32]) == 0;
  endproperty
  a_pup: assert property (p_pup) else $error("upper pend set");
  property p_fall;
    ($past(irq_pending) & ~irq_pending) != 64'h0 |-> $past(wr_acc) && $past(avs_address[31:3]) == ADDR_PEND_CLEAR_LOWER[31:3];
  endproperty
  a_fall: assert property (p_fall) else $error("pending fell");
  property p_rd_en;
    rd_ok && avs_address == ADDR_DISABLE_UPPER |-> ((avs_readdata ^ irq_enabled[63:32]) & UPPER_IMPL_MASK) == 0;
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read");
  property p_rd_pd;
    rd_ok && avs_address == ADDR_PEND_SET_LOWER |-> avs_readdata == $past(irq_pending[31:0]);
  endproperty
  a_rd_pd: assert property (p_rd_pd) else $error("pending read");
  property p_src;
    !irq_src[6] ##1 (irq_src[6] && clk_en)[*4] |=> irq_pending[6];
  endproperty
  a_src: assert property (p_src) else $error("source lost");
endmodule : icep_regs_monitor
bind icep_regs icep_regs_monitor i_mon (.clk(clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_src(irq_src),
  .irq_enabled(irq_enabled), .irq_pending(irq_pending), .irq_active(irq_active));

// ==== testbench/icep_src_model.sv ====
// Interrupt-raising peripheral lines
`timescale 1ns/1ps
module icep_src_model (
  input  wire logic        clk,
  output      logic [63:0] irq_src
);
  // ****************
  // Source events
  // ****************
  initial irq_src = 64'h0;
  task automatic pulse(input int n, input int hold);
    @(posedge clk);
    irq_src[n] <= 1'b1;
    repeat (hold) @(posedge clk);
    irq_src[n] <= 1'b0;
  endtask : pulse
endmodule : icep_src_model

// ==== testbench/icep_regs_tb_top.sv ====
// Self-checking bench for the interrupt register block
`timescale 1ns/1ps
module icep_regs_tb_top;
  import icep_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        avs_waitrequest;
  logic        clk_en = 1'b1;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_address = 32'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, r, d;
  logic [31:0] seed = 32'h50;
  logic [63:0] irq_src, irq_enabled, irq_pending, irq_active, en;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_total, num_checks;
  // ****************
  // Harness
  // ****************
  icep_regs i_dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_src(irq_src), .irq_enabled(irq_enabled),
    .irq_pending(irq_pending), .irq_active(irq_active));
  icep_src_model i_src (.clk(clk), .irq_src(irq_src));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Reads queue the masked expectation; the watcher compares
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= v;
    if (!wr) begin
      exp_q.push_back(v & m);
      msk_q.push_back(m);
    end
    // Wait for the edge that sees waitrequest low; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk(64'(avs_readdata & msk_q.pop_front()), 64'(exp_q.pop_front()));
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, ADDR_DISABLE_UPPER, 32'h0, UPPER_IMPL_MASK);
    bus(1'b0, ADDR_PEND_SET_LOWER, 32'h0, '1);
    r = rnd() & UPPER_IMPL_MASK;
    d = rnd() & UPPER_IMPL_MASK;
    bus(1'b1, ADDR_ENABLE_SET_LOWER, ~r, 0);
    bus(1'b1, ADDR_ENABLE_SET_UPPER, r, 0);
    bus(1'b1, ADDR_DISABLE_UPPER, d, 0);
    bus(1'b1, ADDR_DISABLE_UPPER, 32'h0, 0);
    bus(1'b0, ADDR_DISABLE_UPPER, r & ~d, UPPER_IMPL_MASK);
    for (int k = 0; k < 26; k++) begin
      if (k != 20) begin
        bus(1'b1, ADDR_ENABLE_SET_UPPER, UPPER_IMPL_MASK, 0);
        bus(1'b1, ADDR_DISABLE_UPPER, 32'h1 << k, 0);
        bus(1'b0, ADDR_DISABLE_UPPER, UPPER_IMPL_MASK & ~(32'h1 << k), UPPER_IMPL_MASK);
      end
    end
    @(negedge clk);
    en = {UPPER_IMPL_MASK & ~(32'h1 << BIT_SYNC_SERIAL_B), ~r};
    chk(irq_enabled, en);
    $display("test disable done");
    bus(1'b1, ADDR_PEND_CLEAR_LOWER, '1, 0);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, ADDR_PEND_SET_LOWER, 32'h1 << k, 0);
      bus(1'b0, ADDR_PEND_SET_LOWER, (32'h2 << k) - 1, '1);
    end
    r = rnd();
    bus(1'b1, ADDR_PEND_SET_LOWER, r, 0);
    bus(1'b1, ADDR_PEND_SET_LOWER, 32'h0, 0);
    bus(1'b0, ADDR_PEND_SET_LOWER, r | 32'h1f, '1);
    d = rnd() & UPPER_IMPL_MASK;
    bus(1'b1, ADDR_PEND_SET_UPPER, d, 0);
    @(negedge clk);
    chk(irq_pending, {d, r | 32'h1f});
    chk(irq_active, en & {d, r | 32'h1f});
    bus(1'b1, 32'he000e300, rnd(), 0);
    bus(1'b0, 32'he000e300, 32'h0, '1);
    // Only the enabled lane may land
    avs_byteenable <= 4'h2;
    bus(1'b1, ADDR_PEND_SET_UPPER, 32'hffffffff, 0);
    avs_byteenable <= 4'hf;
    bus(1'b0, ADDR_PEND_SET_UPPER, d | 32'h0000ff00, UPPER_IMPL_MASK);
    $display("test pending done");
    bus(1'b1, ADDR_PEND_CLEAR_LOWER, '1, 0);
    fork
      i_src.pulse(6, 4);
      i_src.pulse(7, 40);
    join_none
    repeat (12) @(posedge clk);
    bus(1'b1, ADDR_PEND_CLEAR_LOWER, 32'h80, 0);
    @(negedge clk);
    chk(64'(irq_pending[7:6]), 64'h1);
    bus(1'b0, ADDR_PEND_SET_LOWER, 32'h40, '1);
    // Source edge and clear land on one edge
    fork
      i_src.pulse(5, 4);
    join_none
    repeat (2) @(posedge clk);
    bus(1'b1, ADDR_PEND_CLEAR_LOWER, 32'h20, 0);
    @(negedge clk);
    chk(64'(irq_pending[5]), 64'h1);
    $display("test source done");
    // Freeze with the write already in its answer cycle
    fork
      begin
        repeat (2) @(posedge clk);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
      end
    join_none
    bus(1'b1, ADDR_PEND_SET_LOWER, 32'h100, 0);
    @(negedge clk);
    chk(64'(irq_pending[8]), 64'h1);
    bus(1'b0, ADDR_PEND_SET_LOWER, 32'h160, '1);
    $display("test freeze done");
    end_sim();
  end
endmodule : icep_regs_tb_top
